// *** ivf_fetch_state.sv ***
// Behaviour
// [R1] cut enabled: all-ones index marks strip cut
// [R2] cut disabled: all-ones is an ordinary index
// [R3] format 0/1/2 selects byte/word/dword, unsigned
// [R4] index packet length is total minus two
// [R5] sender aligns index start to index size
// [R6] index reads past end address return zero
// [R7] sender ends index buffer on index boundary
// [R8] older parts: zero end disables index bounds
// [R9] newer parts: end on 64-byte line last byte
// [R10] undefined indices still bounded by vertex limit
// [R11] index buffers only in linear uncached memory
// [R12] cut only with list and strip topologies
// [R13] vertex access outside buffer returns zero
// [R14] access type picks vertex or instance index
// [R15] vertex packet header codes, length 4n-1
// [R16] up to 17 or 33 vertex buffers
// [R17] vertex packet holds whole four-dword entries
// [R18] each buffer at most once per packet
// [R19] generated-only elements fetch no buffer
// [R20] per-vertex type uses vertex index
// [R21] per-instance type shares data across instance
// [R22] newer parts: straddle past end returns zeros
// [R23] cut test precedes any vertex address math
// [R24] index state precedes random draws, one active
`timescale 1ns/1ps
module ivf_fetch_state
  import ivf_pkg::*;
#(
  parameter bit NEW_GEN = 1'b1,
  parameter int NUM_VB  = NEW_GEN ? 33 : 17
) (
  ivf_cmd_if.dev            cmd,
  input  wire logic         CORE_CLK_I,
  input  wire logic         NRST_I,
  input  wire logic         IDX_REQ_I,
  input  wire logic [31:0]  IDX_ADDR_I,
  input  wire logic [31:0]  IDX_MEM_DATA_I,
  output logic              IDX_VALID_O,
  output logic [31:0]       IDX_VALUE_O,
  output logic              IDX_CUT_O,
  input  wire logic         VTX_REQ_I,
  input  wire logic [5:0]   VTX_BUF_I,
  input  wire logic [31:0]  VTX_VINDEX_I,
  input  wire logic [31:0]  VTX_IINDEX_I,
  input  wire logic [11:0]  VTX_OFFSET_I,
  input  wire logic [4:0]   VTX_BYTES_I,
  input  wire logic         VTX_GENERATED_I,
  output logic              VTX_VALID_O,
  output logic              VTX_FETCH_O,
  output logic              VTX_ZERO_O,
  output logic [31:0]       VTX_ADDR_O,
  output logic              IB_DEFINED_O
);
  function automatic logic [31:0] fmt_ones(input logic [1:0] fmt);
    case (ivf_fmt_t'(fmt))
      WIDTH_EIGHT_BIT:     fmt_ones = 32'h0000_00FF;
      WIDTH_SIXTEEN_BIT:   fmt_ones = 32'h0000_FFFF;
      WIDTH_THIRTYTWO_BIT: fmt_ones = 32'hFFFF_FFFF;
      default:             fmt_ones = 32'hFFFF_FFFF;
    endcase
  endfunction : fmt_ones
  // two-entry buffer in front of the decoder
  logic [31:0] buf_q [2];
  logic        wr_q;
  logic        rd_q;
  logic [1:0]  cnt_q;
  logic        in_ready_q;
  logic        push;
  logic        pop;
  logic        dec_ready;
  logic [31:0] word;
  // lookups read the state tables, so updates wait until none is asked
  assign dec_ready = !(IDX_REQ_I || VTX_REQ_I);
  assign push      = cmd.valid && in_ready_q;
  assign pop       = (cnt_q != 2'h0) && dec_ready;
  assign word      = buf_q[rd_q];
  assign cmd.ready = in_ready_q;
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      buf_q[0] <= '0;
      buf_q[1] <= '0;
      wr_q     <= 1'b0;
      rd_q     <= 1'b0;
    end else begin
      if (push) begin
        buf_q[wr_q] <= cmd.data;
        wr_q        <= !wr_q;
      end
      if (pop) begin
        rd_q <= !rd_q;
      end
    end
  end
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      cnt_q      <= 2'h0;
      in_ready_q <= 1'b0;
    end else begin
      case ({push, pop})
        2'b10:   cnt_q <= cnt_q + 2'h1;
        2'b01:   cnt_q <= cnt_q - 2'h1;
        default: cnt_q <= cnt_q;
      endcase
      // ready from a flop: set only when a slot is sure to be free
      in_ready_q <= (cnt_q == 2'h0) || (cnt_q == 2'h1 && !(push && !pop))
                    || (cnt_q == 2'h2 && pop && !push);
    end
  end
  // packet decoder
  ivf_dec_t    st_q;
  logic [8:0]  rem_q;
  logic [5:0]  sel_q;
  logic [5:0]  hdr_sel;
  logic        hdr_ok;
  assign hdr_ok = word[HDR_TYPE_HI:HDR_TYPE_LO] == PIPELINE_COMMAND_TYPE &&
                  word[HDR_SUB_HI:HDR_SUB_LO] == CMD_SUBTYPE_3D &&
                  word[HDR_OPC_HI:HDR_OPC_LO] == CMD_OPC_PIPELINED;
  assign hdr_sel = NEW_GEN ? word[VB_SEL_NEW_HI:VB_SEL_NEW_LO]
                           : {1'b0, word[VB_SEL_OLD_HI:VB_SEL_OLD_LO]};
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      st_q  <= ST_HDR;
      rem_q <= 9'h000;
    end else if (pop) begin
      rem_q <= rem_q - 9'h001;
      case (st_q)
        ST_HDR: begin
          // payload dwords = length field + 1
          rem_q <= {1'b0, word[HDR_LEN_HI:HDR_LEN_LO]} + 9'h001; // R4 R15
          if (hdr_ok && word[HDR_SOP_HI:HDR_SOP_LO] == SOP_INDEX_SOURCE)
            st_q <= ST_IB_START;
          else if (hdr_ok && word[HDR_SOP_HI:HDR_SOP_LO] == SOP_VERTEX_SOURCE)
            st_q <= ST_VB_W0;
          else
            st_q <= ST_SKIP;
        end
        ST_IB_START: st_q <= ST_IB_END;
        ST_VB_W0:    st_q <= ST_VB_W1;
        ST_VB_W1:    st_q <= ST_VB_W2;
        ST_VB_W2:    st_q <= ST_VB_W3;
        ST_IB_END, ST_VB_W3, ST_SKIP: begin
          if (rem_q == 9'h001)
            st_q <= ST_HDR;
          else if (st_q == ST_VB_W3)
            st_q <= ST_VB_W0; // R17
          else
            st_q <= ST_SKIP;
        end
        default: begin
          st_q  <= ST_HDR;
          rem_q <= 9'h000;
        end
      endcase
    end
  end
  // index buffer state, only one active at a time
  logic        cut_en_q;
  logic [1:0]  fmt_q;
  logic [31:0] ib_start_q;
  logic [31:0] ib_end_q;
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      cut_en_q     <= 1'b0;
      fmt_q        <= WIDTH_EIGHT_BIT;
      ib_start_q   <= '0;
      ib_end_q     <= '0;
      IB_DEFINED_O <= 1'b0;
    end else if (pop) begin
      if (st_q == ST_HDR && hdr_ok &&
          word[HDR_SOP_HI:HDR_SOP_LO] == SOP_INDEX_SOURCE) begin
        cut_en_q <= word[IB_CUT_BIT];
        fmt_q    <= word[IB_FMT_HI:IB_FMT_LO]; // R3
      end
      if (st_q == ST_IB_START)
        ib_start_q <= word; // R5
      if (st_q == ST_IB_END) begin
        ib_end_q     <= word; // R7 R9
        IB_DEFINED_O <= 1'b1; // R24
      end
    end
  end
  // per-buffer vertex state
  logic [31:0] vb_start_q [NUM_VB];
  logic [31:0] vb_limit_q [NUM_VB];
  logic [11:0] vb_pitch_q [NUM_VB];
  logic        vb_inst_q  [NUM_VB];
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      sel_q <= 6'h00;
      for (int i = 0; i < NUM_VB; i++) begin
        vb_start_q[i] <= '0;
        vb_limit_q[i] <= '0;
        vb_pitch_q[i] <= '0;
        vb_inst_q[i]  <= 1'b0;
      end
    end else if (pop) begin
      // selectors beyond the table are dropped
      if (st_q == ST_VB_W0) begin
        sel_q <= hdr_sel;
        if (32'(hdr_sel) < NUM_VB) begin // R16 R18
          vb_pitch_q[hdr_sel] <= word[VB_PITCH_HI:VB_PITCH_LO];
          vb_inst_q[hdr_sel]  <= NEW_GEN ? word[VB_TYPE_NEW]
                                         : word[VB_TYPE_OLD];
        end
      end
      if (st_q == ST_VB_W1 && 32'(sel_q) < NUM_VB)
        vb_start_q[sel_q] <= word;
      if (st_q == ST_VB_W2 && 32'(sel_q) < NUM_VB)
        vb_limit_q[sel_q] <= word;
    end
  end
  // index lookup
  logic [31:0] idx_raw;
  logic        idx_out;
  always_comb begin
    case (ivf_fmt_t'(fmt_q))
      WIDTH_EIGHT_BIT:   idx_raw = 32'(IDX_MEM_DATA_I[8*IDX_ADDR_I[1:0] +: 8]);
      WIDTH_SIXTEEN_BIT: idx_raw = 32'(IDX_MEM_DATA_I[16*IDX_ADDR_I[1] +: 16]);
      default:           idx_raw = IDX_MEM_DATA_I;
    endcase
    // older parts treat a zero end as no bounds at all
    idx_out = (NEW_GEN || ib_end_q != 32'h0) // R8
              && (IDX_ADDR_I > ib_end_q); // R6
  end
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      IDX_VALID_O <= 1'b0;
      IDX_VALUE_O <= '0;
      IDX_CUT_O   <= 1'b0;
    end else begin
      IDX_VALID_O <= IDX_REQ_I;
      IDX_VALUE_O <= idx_out ? 32'h0 : idx_raw; // R6
      IDX_CUT_O   <= IDX_REQ_I && !idx_out && cut_en_q &&
                     idx_raw == fmt_ones(fmt_q); // R1 R2 R23
    end
  end
  // vertex lookup
  logic [31:0] v_idx;
  logic [43:0] v_addr;
  logic [43:0] v_last;
  logic        v_zero;
  logic        v_sel_ok;
  always_comb begin
    v_sel_ok = 32'(VTX_BUF_I) < NUM_VB;
    v_idx    = (v_sel_ok && vb_inst_q[VTX_BUF_I]) ? VTX_IINDEX_I // R14 R21
             : VTX_VINDEX_I; // R20
    v_addr   = 44'(v_sel_ok ? vb_start_q[VTX_BUF_I] : 32'h0)
             + 44'(v_idx) * 44'(v_sel_ok ? vb_pitch_q[VTX_BUF_I] : 12'h0)
             + 44'(VTX_OFFSET_I);
    v_last   = v_addr + 44'(VTX_BYTES_I) - 44'h1;
    if (!v_sel_ok)
      v_zero = 1'b1;
    else if (NEW_GEN)
      v_zero = v_last > 44'(vb_limit_q[VTX_BUF_I]); // R22 R10
    else
      v_zero = vb_limit_q[VTX_BUF_I] != 32'h0 &&
               v_idx > vb_limit_q[VTX_BUF_I]; // R10
  end
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      VTX_VALID_O <= 1'b0;
      VTX_FETCH_O <= 1'b0;
      VTX_ZERO_O  <= 1'b0;
      VTX_ADDR_O  <= '0;
    end else begin
      VTX_VALID_O <= VTX_REQ_I;
      VTX_FETCH_O <= VTX_REQ_I && !VTX_GENERATED_I && !v_zero; // R19 R13
      VTX_ZERO_O  <= VTX_REQ_I && !VTX_GENERATED_I && v_zero; // R13
      VTX_ADDR_O  <= v_addr[31:0];
    end
  end
endmodule : ivf_fetch_state

// *** ivf_pkg.sv ***
package ivf_pkg;

  // command header layout
  localparam int HDR_TYPE_HI    = 31;
  localparam int HDR_TYPE_LO    = 29;
  localparam int HDR_SUB_HI     = 28;
  localparam int HDR_SUB_LO     = 27;
  localparam int HDR_OPC_HI     = 26;
  localparam int HDR_OPC_LO     = 24;
  localparam int HDR_SOP_HI     = 23;
  localparam int HDR_SOP_LO     = 16;
  localparam int HDR_LEN_HI     = 7;
  localparam int HDR_LEN_LO     = 0;
  localparam int IB_CUT_BIT     = 10;
  localparam int IB_FMT_HI      = 9;
  localparam int IB_FMT_LO      = 8;

  localparam logic [2:0] PIPELINE_COMMAND_TYPE = 3'h3;
  localparam logic [1:0] CMD_SUBTYPE_3D        = 2'h3;
  localparam logic [2:0] CMD_OPC_PIPELINED     = 3'h0;
  localparam logic [7:0] SOP_INDEX_SOURCE      = 8'h0A;
  localparam logic [7:0] SOP_VERTEX_SOURCE     = 8'h08;
  localparam logic [7:0] IB_LEN_DEFAULT        = 8'h01;
  localparam logic [7:0] VB_LEN_ONE_ENTRY      = 8'h03;
  localparam logic [7:0] HDR_RSVD              = 8'h00;

  // vertex entry dword 0 layout
  localparam int VB_SEL_OLD_HI  = 31;
  localparam int VB_SEL_OLD_LO  = 27;
  localparam int VB_SEL_NEW_HI  = 31;
  localparam int VB_SEL_NEW_LO  = 26;
  localparam int VB_TYPE_OLD    = 26;
  localparam int VB_TYPE_NEW    = 20;
  localparam int VB_PITCH_HI    = 11;
  localparam int VB_PITCH_LO    = 0;

  localparam logic [5:0] LINE_LOW_ONES = 6'h3F;
  localparam logic [1:0] DW_LOW_ONES   = 2'h3;
  localparam logic       WORD_LOW_ONE  = 1'h1;

  typedef enum logic [1:0] {
    WIDTH_EIGHT_BIT      = 2'h0,
    WIDTH_SIXTEEN_BIT    = 2'h1,
    WIDTH_THIRTYTWO_BIT  = 2'h2
  } ivf_fmt_t;

  typedef enum logic [2:0] {
    ST_HDR      = 3'h0,
    ST_IB_START = 3'h1,
    ST_IB_END   = 3'h3,
    ST_VB_W0    = 3'h2,
    ST_VB_W1    = 3'h6,
    ST_VB_W2    = 3'h7,
    ST_VB_W3    = 3'h5,
    ST_SKIP     = 3'h4
  } ivf_dec_t;

endpackage : ivf_pkg

// *** ivf_cmd_if.sv ***
`timescale 1ns/1ps
interface ivf_cmd_if;
  logic        valid;
  logic        ready;
  logic [31:0] data;

  modport dev (input valid, input data, output ready);
  modport src (output valid, output data, input ready);
endinterface : ivf_cmd_if

// *** ivf_cmd_src.sv ***
`timescale 1ns/1ps
module ivf_cmd_src
  import ivf_pkg::*;
#(
  parameter bit NEW_GEN = 1'b1
) (
  ivf_cmd_if.src            cmd,
  input  wire logic         CORE_CLK_I,
  input  wire logic         NRST_I,
  input  wire logic         IB_SEND_I,
  input  wire logic         IB_CUT_I,
  input  wire logic [1:0]   IB_FMT_I,
  input  wire logic [31:0]  IB_START_I,
  input  wire logic [31:0]  IB_END_I,
  input  wire logic         VB_SEND_I,
  input  wire logic [5:0]   VB_SEL_I,
  input  wire logic         VB_INSTANCE_I,
  input  wire logic [11:0]  VB_PITCH_I,
  input  wire logic [31:0]  VB_START_I,
  input  wire logic [31:0]  VB_LIMIT_I,
  input  wire logic [31:0]  VB_STEP_I,
  output logic              BUSY_O
);

  logic [31:0] pkt_q [5];
  logic [2:0]  rem_q;
  logic [31:0] ib_start;
  logic [31:0] ib_end;
  logic [31:0] vb_w0;
  logic        idle;

  assign idle = (rem_q == 3'h0);

  // start aligned to one index, end on the last byte of an index
  always_comb begin
    ib_start = IB_START_I; // R5
    ib_end   = IB_END_I; // R7
    case (ivf_fmt_t'(IB_FMT_I))
      WIDTH_SIXTEEN_BIT: begin
        ib_start[0] = 1'b0;
        ib_end[0]   = WORD_LOW_ONE;
      end
      WIDTH_THIRTYTWO_BIT: begin
        ib_start[1:0] = 2'h0;
        ib_end[1:0]   = DW_LOW_ONES;
      end
      default: begin
      end
    endcase
    if (NEW_GEN) begin
      ib_end[5:0] = LINE_LOW_ONES; // R9
    end
  end

  always_comb begin
    vb_w0 = '0;
    vb_w0[VB_PITCH_HI:VB_PITCH_LO] = VB_PITCH_I;
    if (NEW_GEN) begin
      vb_w0[VB_SEL_NEW_HI:VB_SEL_NEW_LO] = VB_SEL_I;
      vb_w0[VB_TYPE_NEW] = VB_INSTANCE_I;
    end else begin
      vb_w0[VB_SEL_OLD_HI:VB_SEL_OLD_LO] = VB_SEL_I[4:0];
      vb_w0[VB_TYPE_OLD] = VB_INSTANCE_I;
    end
  end

  // one packet at a time; a vertex packet carries exactly one full entry
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rem_q <= 3'h0;
      for (int i = 0; i < 5; i++) begin
        pkt_q[i] <= '0;
      end
    end else if (idle && IB_SEND_I) begin
      pkt_q[0] <= {PIPELINE_COMMAND_TYPE, CMD_SUBTYPE_3D, CMD_OPC_PIPELINED,
                   SOP_INDEX_SOURCE, 5'h00, IB_CUT_I, IB_FMT_I,
                   IB_LEN_DEFAULT}; // R4
      pkt_q[1] <= ib_start;
      pkt_q[2] <= ib_end;
      pkt_q[3] <= '0;
      pkt_q[4] <= '0;
      rem_q    <= 3'h3;
    end else if (idle && VB_SEND_I) begin
      pkt_q[0] <= {PIPELINE_COMMAND_TYPE, CMD_SUBTYPE_3D, CMD_OPC_PIPELINED,
                   SOP_VERTEX_SOURCE, HDR_RSVD, VB_LEN_ONE_ENTRY}; // R15
      pkt_q[1] <= vb_w0; // R17 R18
      pkt_q[2] <= VB_START_I;
      pkt_q[3] <= VB_LIMIT_I;
      pkt_q[4] <= VB_STEP_I;
      rem_q    <= 3'h5;
    end else if (!idle && cmd.ready) begin
      for (int i = 0; i < 4; i++) begin
        pkt_q[i] <= pkt_q[i+1];
      end
      pkt_q[4] <= '0;
      rem_q    <= rem_q - 3'h1;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      BUSY_O <= 1'b0;
    end else begin
      BUSY_O <= !(rem_q == 3'h0 || (rem_q == 3'h1 && cmd.ready)) ||
                (idle && (IB_SEND_I || VB_SEND_I));
    end
  end

  assign cmd.valid = !idle;
  assign cmd.data  = pkt_q[0];

endmodule : ivf_cmd_src

// *** ivf_fetch_state_checker.sv ***
`timescale 1ns/1ps
module ivf_fetch_state_checker
  import ivf_pkg::*;
(
  input  wire logic        CORE_CLK_I,
  input  wire logic        NRST_I,
  input  wire logic        valid,
  input  wire logic        ready,
  input  wire logic [31:0] data
);
  logic [3:0] rem_q;
  logic       ib_q;
  logic [1:0] fmt_q;
  logic       tk;
  logic       hdr;
  logic       sop_ib;

  assign tk     = valid && ready;
  assign hdr    = tk && rem_q == 4'h0;
  assign sop_ib = data[HDR_SOP_HI:HDR_SOP_LO] == SOP_INDEX_SOURCE;

  // tracks position in packet; assumes short lengths only
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rem_q <= 4'h0;
      ib_q  <= 1'b0;
      fmt_q <= 2'h0;
    end else if (hdr) begin
      rem_q <= data[3:0] + 4'h1;
      ib_q  <= sop_ib;
      fmt_q <= data[IB_FMT_HI:IB_FMT_LO];
    end else if (tk) begin
      rem_q <= rem_q - 4'h1;
    end
  end

  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!NRST_I);

  property p_hold;
    valid && !ready |=> valid && $stable(data);
  endproperty
  a_hold: assert property (p_hold)
    else $error("word changed before taken");
  property p_codes;
    hdr |-> data[31:29] == PIPELINE_COMMAND_TYPE && data[28:27] == 2'h3
      && data[26:24] == CMD_OPC_PIPELINED;
  endproperty
  a_codes: assert property (p_codes)
    else $error("bad header codes");
  property p_rsvd;
    hdr && !sop_ib |-> data[15:8] == HDR_RSVD;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved bits set");
  property p_vb_len;
    hdr && !sop_ib |-> data[7:0] == VB_LEN_ONE_ENTRY;
  endproperty
  a_vb_len: assert property (p_vb_len)
    else $error("bad vertex length");
  property p_ib_len;
    hdr && sop_ib |-> data[7:0] == IB_LEN_DEFAULT;
  endproperty
  a_ib_len: assert property (p_ib_len)
    else $error("bad index length");
  property p_fmt;
    hdr && sop_ib |-> data[9:8] != 2'h3;
  endproperty
  a_fmt: assert property (p_fmt)
    else $error("bad index format");
  property p_start;
    tk && ib_q && rem_q == 4'h2 |-> (fmt_q != 2'h1 || !data[0])
      && (fmt_q != 2'h2 || data[1:0] == 2'h0);
  endproperty
  a_start: assert property (p_start)
    else $error("start not aligned");
  property p_end;
    tk && ib_q && rem_q == 4'h1 |-> data[5:0] == LINE_LOW_ONES;
  endproperty
  a_end: assert property (p_end)
    else $error("end not on line end");
endmodule : ivf_fetch_state_checker

// *** ivf_fetch_state_tb.sv ***
`timescale 1ns/1ps
module ivf_fetch_state_tb
  import ivf_pkg::*;
;
  logic        clk, rst_n, ib_send, ib_cut, vb_send, vb_inst, busy, ib_def;
  logic        idx_req, idx_vld, idx_cut, vtx_req, vtx_gen;
  logic        vtx_vld, vtx_fetch, vtx_zero;
  logic [1:0]  ib_fmt;
  logic [4:0]  vtx_bytes, b;
  logic [5:0]  vb_sel, vtx_buf;
  logic [11:0] vb_pitch, vtx_off, off;
  logic [31:0] ib_start, ib_end, vb_start, vb_limit, vb_step, idx_addr;
  logic [31:0] idx_mem, idx_val, vtx_vi, vtx_ii, vtx_addr, vi, ii, sz, a0;
  int          failures, n_compared, f, k;

  ivf_cmd_if ivf_cmd_if_inst ();
  ivf_cmd_src #(.NEW_GEN(1'b1)) ivf_cmd_src_inst (
    .cmd(ivf_cmd_if_inst), .CORE_CLK_I(clk), .NRST_I(rst_n),
    .IB_SEND_I(ib_send), .IB_CUT_I(ib_cut), .IB_FMT_I(ib_fmt),
    .IB_START_I(ib_start), .IB_END_I(ib_end), .VB_SEND_I(vb_send),
    .VB_SEL_I(vb_sel), .VB_INSTANCE_I(vb_inst), .VB_PITCH_I(vb_pitch),
    .VB_START_I(vb_start), .VB_LIMIT_I(vb_limit), .VB_STEP_I(vb_step),
    .BUSY_O(busy));
  ivf_fetch_state #(.NEW_GEN(1'b1)) ivf_fetch_state_inst (
    .cmd(ivf_cmd_if_inst), .CORE_CLK_I(clk), .NRST_I(rst_n),
    .IDX_REQ_I(idx_req), .IDX_ADDR_I(idx_addr), .IDX_MEM_DATA_I(idx_mem),
    .IDX_VALID_O(idx_vld), .IDX_VALUE_O(idx_val), .IDX_CUT_O(idx_cut),
    .VTX_REQ_I(vtx_req), .VTX_BUF_I(vtx_buf), .VTX_VINDEX_I(vtx_vi),
    .VTX_IINDEX_I(vtx_ii), .VTX_OFFSET_I(vtx_off), .VTX_BYTES_I(vtx_bytes),
    .VTX_GENERATED_I(vtx_gen), .VTX_VALID_O(vtx_vld),
    .VTX_FETCH_O(vtx_fetch), .VTX_ZERO_O(vtx_zero), .VTX_ADDR_O(vtx_addr),
    .IB_DEFINED_O(ib_def));
  ivf_fetch_state_checker ivf_fetch_state_checker_inst (
    .CORE_CLK_I(clk), .NRST_I(rst_n), .valid(ivf_cmd_if_inst.valid),
    .ready(ivf_cmd_if_inst.ready), .data(ivf_cmd_if_inst.data));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  task automatic launch(input logic ib);
    @(negedge clk);
    {ib_send, vb_send} = {ib, !ib};
    @(negedge clk);
    {ib_send, vb_send} = 2'h0;
  endtask : launch

  // lookups block draining, so only wait while idle
  task automatic finish_pkt();
    int i;
    for (i = 0; i < 40 && busy; i++) @(negedge clk);
    cmp({31'h0, busy}, 32'h0);
    repeat (3) @(negedge clk);
  endtask : finish_pkt

  function automatic logic [32:0] exp_idx(input logic [31:0] a, m);
    logic [31:0] v, ones;
    v = ib_fmt == 2'h0 ? {24'h0, m[{a[1:0], 3'h0} +: 8]} :
        ib_fmt == 2'h1 ? {16'h0, m[{a[1], 4'h0} +: 16]} : m;
    ones = ib_fmt == 2'h0 ? 32'hFF : ib_fmt == 2'h1 ? 32'hFFFF : 32'hFFFFFFFF;
    if (a > ib_end) return 33'h0;
    return {ib_cut && v == ones, v};
  endfunction : exp_idx

  task automatic idx_chk(input logic [31:0] a, m);
    logic [32:0] e;
    e = exp_idx(a, m);
    @(negedge clk);
    {idx_req, idx_addr, idx_mem} = {1'b1, a, m};
    @(negedge clk);
    idx_req = 1'b0;
    cmp({31'h0, idx_vld}, 32'h1);
    cmp(idx_val, e[31:0]);
    cmp({31'h0, idx_cut}, {31'h0, e[32]});
  endtask : idx_chk

  task automatic vtx_chk(input logic [5:0] s, input logic [31:0] v, i,
                         input logic [11:0] o, input logic [4:0] n,
                         input logic g);
    logic [31:0] x, e;
    logic        ok;
    x = vb_start + (vb_inst ? i : v) * {20'h0, vb_pitch} + {20'h0, o};
    ok = !g && s < 6'h21 && x + {27'h0, n} - 32'h1 <= vb_limit;
    e = {29'h0, 1'b1, ok, !g && !ok};
    @(negedge clk);
    {vtx_req, vtx_buf, vtx_vi, vtx_ii, vtx_off, vtx_bytes, vtx_gen} =
      {1'b1, s, v, i, o, n, g};
    @(negedge clk);
    vtx_req = 1'b0;
    cmp({29'h0, vtx_vld, vtx_fetch, vtx_zero}, e);
    if (ok) cmp(vtx_addr, x);
  endtask : vtx_chk

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    summarize();
  end

  initial begin
    {rst_n, ib_send, ib_cut, vb_send, vb_inst, idx_req, vtx_req} = 7'h0;
    {vtx_gen, ib_fmt, vb_sel, vtx_buf, vb_pitch, vtx_off, vtx_bytes} = 44'h0;
    {ib_start, ib_end, vb_start, vb_limit, vb_step} = 160'h0;
    {idx_addr, idx_mem, vtx_vi, vtx_ii} = 128'h0;
    failures = 0;
    n_compared = 0;
    void'($urandom(73));
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    cmp({31'h0, ib_def}, 32'h0);
    for (f = 0; f < 6; f++) begin
      ib_fmt = 2'(f / 2);
      ib_cut = f[0];
      sz = 32'h1 << ib_fmt;
      ib_end = {1'b0, 25'($urandom), 6'h3F};
      ib_start = ib_end & 32'hFFFF_F000;
      a0 = ib_end & ~(sz - 32'h1);
      launch(1'b1);
      finish_pkt();
      cmp({31'h0, ib_def}, 32'h1);
      idx_chk(a0, 32'hFFFF_FFFF);
      idx_chk(ib_end + 32'h1, 32'hFFFF_FFFF);
      for (k = 0; k < 4; k++) begin
        idx_chk(a0 - sz * 32'($urandom_range(15)), $urandom);
      end
    end
    $display("test index done");
    for (k = 0; k < 6; k++) begin
      vb_sel = 6'($urandom_range(32));
      vb_inst = k[0];
      vb_pitch = 12'($urandom);
      vb_start = $urandom & 32'h0FFF_FFF0;
      vb_step = $urandom;
      vi = $urandom & 32'hFFFF;
      ii = $urandom & 32'hFFFF;
      off = 12'($urandom_range(2047));
      b = 5'($urandom_range(16, 1));
      // limit lands exactly on the element's last byte
      vb_limit = vb_start + (vb_inst ? ii : vi) * {20'h0, vb_pitch}
                 + {20'h0, off} + {27'h0, b} - 32'h1;
      launch(1'b0);
      finish_pkt();
      vtx_chk(vb_sel, vi, ii, off, b, 1'b0);
      vtx_chk(vb_sel, vi, ii, off + 12'h1, b, 1'b0);
      vtx_chk(vb_sel, vi ^ 32'h1, ii, off, b, 1'b0);
      vtx_chk(vb_sel, vi, ii, off, b, 1'b1);
      vtx_chk(6'h21 + 6'(k), vi, ii, off, b, 1'b0);
    end
    $display("test vertex done");
    vb_sel = 6'h0;
    vb_limit = 32'hFFFF_FFFF;
    @(negedge clk);
    idx_req = 1'b1;
    launch(1'b0);
    repeat (6) @(negedge clk);
    cmp({31'h0, ivf_cmd_if_inst.ready}, 32'h0);
    cmp({31'h0, busy}, 32'h1);
    idx_req = 1'b0;
    finish_pkt();
    vtx_chk(6'h0, vi, ii, off, b, 1'b0);
    $display("test stall done");
    summarize();
  end
endmodule : ivf_fetch_state_tb
